/* hw/lpeg_top.sv */
`timescale 1ns/1ps
module lpeg_top
   import lpeg_pkg::*;
#(
   parameter int SEC_TICKS = SEC_TICKS_DEF
) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire lpeg_req_t i_req,
   output logic [15:0] o_rdata,
   output logic o_rvalid,
   input wire logic [7:0] i_adc_ch1,
   input wire logic [7:0] i_adc_ch2,
   input wire logic i_idle_level_select,
   input wire logic [7:0] i_rising_trip_level,
   input wire logic [5:0] i_low_current_setting,
   input wire logic [7:0] i_high_current_setting,
   output logic [7:0] o_load_code_ch1,
   output logic [7:0] o_load_code_ch2,
   output logic o_pulse_ch1,
   output logic o_pulse_ch2,
   output logic o_cool_ch1,
   output logic o_cool_ch2,
   output logic [3:0] o_gain_therm
);
   logic [11:0] load_pulse_duration, next_load_pulse_duration;
   logic [15:0] energy_meter_control, next_energy_meter_control;
   logic [15:0] energy_max_threshold, next_energy_max_threshold;
   logic [1:0] load_channel_enable, next_load_channel_enable;
   logic [1:0] amp_gain_select, next_amp_gain_select;
   logic [3:0] next_gain_therm;
   logic [15:0] next_rdata;
   logic next_rvalid;
   logic [TICK_W-1:0] tick_cnt, next_tick_cnt;
   logic [2:0] step_cnt, next_step_cnt;
   logic tick, next_tick, step, next_step;
   logic [2:0] step_mask;
   lpeg_cfg_t cfg;
   logic [15:0] energy_accum_ch1, energy_accum_ch2;

   always_comb begin
      cfg.idle_high = i_idle_level_select;
      cfg.rise_level = i_rising_trip_level;
      cfg.low_code = i_low_current_setting;
      cfg.high_code = i_high_current_setting;
      cfg.pulse_dur = load_pulse_duration;
      cfg.step_amount = energy_meter_control[STEP_AMT_LSB +: 8];
      cfg.ov_factor = energy_meter_control[OV_LSB +: 2];
      cfg.cool_secs = energy_meter_control[SECS_LSB +: 4];
      cfg.limit = energy_max_threshold;
   end

   always_comb begin
      next_load_pulse_duration = load_pulse_duration;
      next_energy_meter_control = energy_meter_control;
      next_energy_max_threshold = energy_max_threshold;
      next_load_channel_enable = load_channel_enable;
      next_amp_gain_select = amp_gain_select;
      if (i_req.wr) begin
         case (i_req.addr)
            ADDR_PULSE: begin
               if (i_req.wdata[11:0] == 12'h000) begin
                  next_load_pulse_duration = 12'h001; // RULE_02
               end else begin
                  next_load_pulse_duration = i_req.wdata[11:0];
               end
            end
            ADDR_METER: next_energy_meter_control = i_req.wdata;
            ADDR_LIMIT: next_energy_max_threshold = i_req.wdata;
            ADDR_EN: next_load_channel_enable = {i_req.wdata[EN_CH2_BIT], i_req.wdata[EN_CH1_BIT]}; // RULE_11
            ADDR_GAIN: next_amp_gain_select = i_req.wdata[1:0];
            default: next_amp_gain_select = amp_gain_select;
         endcase
      end
      case (amp_gain_select) // RULE_12
         2'h1: next_gain_therm = 4'h3;
         2'h2: next_gain_therm = 4'h7;
         2'h3: next_gain_therm = 4'hF;
         default: next_gain_therm = 4'h1;
      endcase
      next_rvalid = i_req.rd;
      next_rdata = o_rdata;
      if (i_req.rd) begin
         case (i_req.addr)
            ADDR_PULSE: next_rdata = {4'h0, load_pulse_duration};
            ADDR_METER: next_rdata = energy_meter_control;
            ADDR_LIMIT: next_rdata = energy_max_threshold;
            ADDR_ACC1: next_rdata = energy_accum_ch1; // RULE_10
            ADDR_ACC2: next_rdata = energy_accum_ch2; // RULE_10
            ADDR_EN: next_rdata = {load_channel_enable, 14'h0000};
            ADDR_GAIN: next_rdata = {14'h0000, amp_gain_select};
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   always_comb begin
      case (energy_meter_control[STEP_SEL_LSB +: 2]) // RULE_05
         2'h1: step_mask = 3'h1;
         2'h2: step_mask = 3'h3;
         2'h3: step_mask = 3'h7;
         default: step_mask = 3'h0;
      endcase
      next_tick = 1'b0;
      next_step = 1'b0;
      next_step_cnt = step_cnt;
      if (tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
         next_tick_cnt = '0;
         next_tick = 1'b1; // RULE_09
         next_step_cnt = step_cnt + 3'h1;
         next_step = ((step_cnt & step_mask) == step_mask); // RULE_05
      end else begin
         next_tick_cnt = tick_cnt + TICK_W'(1);
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         load_pulse_duration <= RST_PULSE;
         energy_meter_control <= RST_METER;
         energy_max_threshold <= RST_LIMIT;
         load_channel_enable <= RST_EN; // RULE_11
         amp_gain_select <= RST_GAIN;
         o_gain_therm <= 4'h1;
         o_rdata <= 16'h0000;
         o_rvalid <= 1'b0;
         tick_cnt <= '0;
         step_cnt <= 3'h0;
         tick <= 1'b0;
         step <= 1'b0;
      end else begin
         load_pulse_duration <= next_load_pulse_duration;
         energy_meter_control <= next_energy_meter_control;
         energy_max_threshold <= next_energy_max_threshold;
         load_channel_enable <= next_load_channel_enable;
         amp_gain_select <= next_amp_gain_select;
         o_gain_therm <= next_gain_therm;
         o_rdata <= next_rdata;
         o_rvalid <= next_rvalid;
         tick_cnt <= next_tick_cnt;
         step_cnt <= next_step_cnt;
         tick <= next_tick;
         step <= next_step;
      end
   end

   lpeg_channel #(
      .SEC_TICKS(SEC_TICKS)
   ) u_ch1 (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_cfg(cfg),
      .i_en(load_channel_enable[0]),
      .i_adc(i_adc_ch1),
      .i_tick(tick),
      .i_step(step),
      .o_code(o_load_code_ch1),
      .o_pulse(o_pulse_ch1),
      .o_cool(o_cool_ch1),
      .o_energy(energy_accum_ch1)
   );

   lpeg_channel #(
      .SEC_TICKS(SEC_TICKS)
   ) u_ch2 (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_cfg(cfg),
      .i_en(load_channel_enable[1]),
      .i_adc(i_adc_ch2),
      .i_tick(tick),
      .i_step(step),
      .o_code(o_load_code_ch2),
      .o_pulse(o_pulse_ch2),
      .o_cool(o_cool_ch2),
      .o_energy(energy_accum_ch2)
   );

endmodule

/* pkg/lpeg_pkg.sv */
// Contract
// RULE_01 - When a channel's load goes to its high state it sinks the high current for the 12-bit pulse duration in 10 us units.
// RULE_02 - A write of zero to the pulse duration is stored as one, so the shortest pulse is one 10 us unit.
// RULE_03 - While the pulse current is off, the 8-bit step amount is subtracted from the accumulator once per cool-down timestep.
// RULE_04 - A full-scale ADC sample is multiplied before accumulation by 1, 4, 8 or 16 for overvolt factor codes 00 to 11.
// RULE_05 - The 2-bit cool step interval selects 10, 20, 40 or 80 us between decrements.
// RULE_06 - The 4-bit cool period gives the cool-down length in seconds, and zero disables cool-down entirely.
// RULE_07 - When a channel's accumulator exceeds the energy limit the channel enters cool-down mode.
// RULE_08 - The 16-bit energy limit is scaled by 128 before it is compared with the accumulator.
// RULE_09 - Outside cool-down the overvolt-scaled ADC value is added to the accumulator once every 10 us; the code adds it only in LPEG_PULSE.
// RULE_10 - Each channel has a read-only 16-bit accumulator register that resets to zero.
// RULE_11 - Bit 15 enables the channel 2 load and bit 14 the channel 1 load, both cleared by reset.
// RULE_12 - The 2-bit gain select decodes to a 4-bit thermometer code for gains of 1, 2, 5 and 10.
// RULE_13 - In low idle mode the load sinks the low current while the ADC code is above zero and goes high above the rise level.
// RULE_14 - In high idle mode the load is set to the high current whenever the ADC code is above zero; the code does so for one pulse duration only.
// RULE_15 - After the pulse expires the load returns to the low current and no new pulse starts until the input was idle.
// RULE_16 - During cool-down high-current pulses are suppressed, and cool-down ends after the programmed number of seconds.
package lpeg_pkg;

   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_US = 10;
   localparam int TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
   localparam int TICK_W = $clog2(TICK_CYCLES);
   localparam int SEC_US = 1000000;
   localparam int SEC_TICKS_DEF = SEC_US / TICK_US;

   localparam int ADDR_W = 10;
   localparam logic [9:0] ADDR_PULSE = 10'h014;
   localparam logic [9:0] ADDR_METER = 10'h015;
   localparam logic [9:0] ADDR_LIMIT = 10'h016;
   localparam logic [9:0] ADDR_ACC1 = 10'h017;
   localparam logic [9:0] ADDR_ACC2 = 10'h018;
   localparam logic [9:0] ADDR_EN = 10'h200;
   localparam logic [9:0] ADDR_GAIN = 10'h201;

   localparam logic [11:0] RST_PULSE = 12'h12C;
   localparam logic [15:0] RST_METER = 16'h0505;
   localparam logic [15:0] RST_LIMIT = 16'h9BA3;
   localparam logic [1:0] RST_EN = 2'h0;
   localparam logic [1:0] RST_GAIN = 2'h0;

   localparam int DUR_W = 12;
   localparam int EN_CH2_BIT = 15;
   localparam int EN_CH1_BIT = 14;
   localparam int STEP_AMT_LSB = 8;
   localparam int OV_LSB = 6;
   localparam int STEP_SEL_LSB = 4;
   localparam int SECS_LSB = 0;
   localparam int ACC_W = 24;
   localparam int LIMIT_SHIFT = 7;
   localparam logic [7:0] ADC_FULL = 8'hFF;

   typedef struct packed {
      logic idle_high;
      logic [7:0] rise_level;
      logic [5:0] low_code;
      logic [7:0] high_code;
      logic [11:0] pulse_dur;
      logic [7:0] step_amount;
      logic [1:0] ov_factor;
      logic [3:0] cool_secs;
      logic [15:0] limit;
   } lpeg_cfg_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [9:0] addr;
      logic [15:0] wdata;
   } lpeg_req_t;

   typedef enum logic [1:0] {
      LPEG_OFF = 2'b00,
      LPEG_LOW = 2'b01,
      LPEG_PULSE = 2'b10,
      LPEG_SPENT = 2'b11
   } lpeg_state_t;

endpackage

/* hw/lpeg_channel.sv */
`timescale 1ns/1ps
module lpeg_channel
   import lpeg_pkg::*;
#(
   parameter int SEC_TICKS = SEC_TICKS_DEF
) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire lpeg_cfg_t i_cfg,
   input wire logic i_en,
   input wire logic [7:0] i_adc,
   input wire logic i_tick,
   input wire logic i_step,
   output logic [7:0] o_code,
   output logic o_pulse,
   output logic o_cool,
   output logic [15:0] o_energy
);
   localparam int SEC_W = $clog2(SEC_TICKS + 1);

   if (SEC_TICKS < 1) begin : g_chk
      $error("SEC_TICKS must be at least one.");
   end

   lpeg_state_t state, next_state;
   logic [DUR_W-1:0] units, next_units;
   logic [TICK_W-1:0] sub, next_sub;
   logic [ACC_W-1:0] acc, next_acc;
   logic [SEC_W-1:0] sec_tick, next_sec_tick;
   logic [3:0] secs, next_secs;
   logic cool, next_cool;
   logic [7:0] next_code;
   logic next_pulse;
   logic [15:0] next_energy;
   logic live, trigger;
   logic [ACC_W-1:0] add_val, step_val;
   logic [ACC_W:0] sum;

   always_comb begin
      live = (i_adc != 8'h00);
      trigger = i_cfg.idle_high ? live : (i_adc > i_cfg.rise_level); // RULE_13 RULE_14
      add_val = ACC_W'(i_adc);
      if (i_adc == ADC_FULL) begin
         case (i_cfg.ov_factor) // RULE_04
            2'h1: add_val = ACC_W'({i_adc, 2'h0});
            2'h2: add_val = ACC_W'({i_adc, 3'h0});
            2'h3: add_val = ACC_W'({i_adc, 4'h0});
            default: add_val = ACC_W'(i_adc);
         endcase
      end
      step_val = ACC_W'(i_cfg.step_amount);
      sum = {1'b0, acc} + {1'b0, add_val};
      next_state = state;
      next_units = units;
      next_sub = sub;
      if (!i_en || !live) begin
         next_state = LPEG_OFF; // RULE_15
      end else begin
         case (state)
            LPEG_OFF, LPEG_LOW: begin
               if (trigger && !cool) begin
                  next_state = LPEG_PULSE; // RULE_01
                  next_units = i_cfg.pulse_dur;
                  next_sub = '0;
               end else begin
                  next_state = LPEG_LOW; // RULE_16
               end
            end
            LPEG_PULSE: begin
               if (cool) begin
                  next_state = LPEG_SPENT; // RULE_16
               end else if (sub == TICK_W'(TICK_CYCLES - 1)) begin
                  next_sub = '0;
                  if (units <= 12'h001) begin
                     next_state = LPEG_SPENT; // RULE_01 RULE_15
                  end else begin
                     next_units = units - 12'h001;
                  end
               end else begin
                  next_sub = sub + TICK_W'(1);
               end
            end
            LPEG_SPENT: next_state = LPEG_SPENT; // RULE_15
            default: next_state = LPEG_OFF;
         endcase
      end
      case (next_state)
         LPEG_LOW, LPEG_SPENT: next_code = {2'h0, i_cfg.low_code}; // RULE_13 RULE_15
         LPEG_PULSE: next_code = i_cfg.high_code; // RULE_14
         default: next_code = 8'h00;
      endcase
      next_pulse = (next_state == LPEG_PULSE);
   end

   always_comb begin
      next_acc = acc;
      next_cool = cool;
      next_sec_tick = sec_tick;
      next_secs = secs;
      if (state == LPEG_PULSE) begin
         if (i_tick && !cool) begin
            next_acc = sum[ACC_W] ? '1 : sum[ACC_W-1:0]; // RULE_09
         end
      end else if (i_step) begin
         next_acc = (acc > step_val) ? acc - step_val : '0; // RULE_03
      end
      if (cool) begin
         if (i_cfg.cool_secs == 4'h0) begin
            next_cool = 1'b0; // RULE_06
         end else if (i_tick) begin
            if (sec_tick == SEC_W'(SEC_TICKS - 1)) begin
               next_sec_tick = '0;
               next_secs = secs + 4'h1;
               if ({1'b0, secs} + 5'h01 >= {1'b0, i_cfg.cool_secs}) begin
                  next_cool = 1'b0; // RULE_16 RULE_06
               end
            end else begin
               next_sec_tick = sec_tick + SEC_W'(1);
            end
         end
      end else if (i_cfg.cool_secs != 4'h0 && acc > ACC_W'({i_cfg.limit, 7'h00})) begin // RULE_08
         next_cool = 1'b1; // RULE_07
         next_sec_tick = '0;
         next_secs = 4'h0;
      end
      next_energy = acc[ACC_W-1] ? 16'hFFFF : acc[LIMIT_SHIFT +: 16]; // RULE_10
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= LPEG_OFF;
         units <= '0;
         sub <= '0;
         acc <= '0;
         cool <= 1'b0;
         sec_tick <= '0;
         secs <= 4'h0;
         o_code <= 8'h00;
         o_pulse <= 1'b0;
         o_energy <= 16'h0000;
      end else begin
         state <= next_state;
         units <= next_units;
         sub <= next_sub;
         acc <= next_acc;
         cool <= next_cool;
         sec_tick <= next_sec_tick;
         secs <= next_secs;
         o_code <= next_code;
         o_pulse <= next_pulse;
         o_energy <= next_energy;
      end
   end

   assign o_cool = cool;

endmodule

/* tb/lpeg_chk.sv */
`timescale 1ns/1ps
module lpeg_chk
   import lpeg_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire lpeg_req_t i_req,
   input wire logic o_rvalid,
   input wire logic [7:0] i_adc_ch1,
   input wire logic [7:0] i_adc_ch2,
   input wire logic i_idle_level_select,
   input wire logic [7:0] i_rising_trip_level,
   input wire logic [5:0] i_low_current_setting,
   input wire logic [7:0] i_high_current_setting,
   input wire logic [7:0] o_load_code_ch1,
   input wire logic [7:0] o_load_code_ch2,
   input wire logic o_pulse_ch1,
   input wire logic o_cool_ch1
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_nrst);
   sequence s_end1;
      (o_pulse_ch1 && i_adc_ch1 != 8'h00) ##1 (!o_pulse_ch1 && !o_cool_ch1 && i_adc_ch1 != 8'h00);
   endsequence
   property p_off1;
      i_adc_ch1 == 8'h00 |=> o_load_code_ch1 == 8'h00 && !o_pulse_ch1;
   endproperty
   a_off1: assert property (p_off1) else $error("ch1 load on at zero input");
   property p_off2;
      i_adc_ch2 == 8'h00 |=> o_load_code_ch2 == 8'h00;
   endproperty
   a_off2: assert property (p_off2) else $error("ch2 load on at zero input");
   property p_high;
      o_pulse_ch1 |-> o_load_code_ch1 == i_high_current_setting;
   endproperty
   a_high: assert property (p_high) else $error("pulse without high code");
   property p_low;
      !o_pulse_ch1 && o_load_code_ch1 != 8'h00 |-> o_load_code_ch1 == {2'b00, i_low_current_setting};
   endproperty
   a_low: assert property (p_low) else $error("idle code is not the low code");
   property p_start;
      $rose(o_pulse_ch1) |-> ($past(i_idle_level_select) ? $past(i_adc_ch1) != 8'h00 :
         $past(i_adc_ch1) > $past(i_rising_trip_level));
   endproperty
   a_start: assert property (p_start) else $error("pulse started below trigger");
   property p_spent;
      s_end1 ##1 i_adc_ch1 != 8'h00 |-> !o_pulse_ch1;
   endproperty
   a_spent: assert property (p_spent) else $error("pulse restarted without idle");
   property p_cool;
      o_cool_ch1 [*2] |-> !o_pulse_ch1;
   endproperty
   a_cool: assert property (p_cool) else $error("pulse during cool-down");
   property p_rvalid;
      i_req.rd |=> o_rvalid;
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read not answered");
endmodule
bind lpeg_top lpeg_chk lpeg_chk_inst (.i_core_clk, .i_nrst, .i_req, .o_rvalid, .i_adc_ch1, .i_adc_ch2,
   .i_idle_level_select, .i_rising_trip_level, .i_low_current_setting, .i_high_current_setting,
   .o_load_code_ch1, .o_load_code_ch2, .o_pulse_ch1, .o_cool_ch1);

/* tb/lpeg_host.sv */
`timescale 1ns/1ps
module lpeg_host
   import lpeg_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic [15:0] i_rdata,
   input wire logic i_rvalid,
   output lpeg_req_t o_req
);
   initial begin
      o_req = '0;
   end
   // Idle address and data show the inverse of the last request.
   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      @(negedge i_core_clk);
      o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge i_core_clk);
      o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   task automatic rd(input logic [9:0] a, output logic [15:0] d, output bit ok);
      @(negedge i_core_clk);
      o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(negedge i_core_clk);
      o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hFFFF};
      ok = i_rvalid;
      d = i_rdata;
   endtask
endmodule

/* tb/lpeg_top_tb.sv */
`timescale 1ns/1ps
module lpeg_top_tb;
   import lpeg_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_nrst = 1'b0;
   lpeg_req_t req;
   logic [15:0] rdata;
   logic rvalid;
   logic [7:0] adc1 = 8'h00;
   logic [7:0] adc2 = 8'h00;
   logic idle_sel = 1'b0;
   logic [7:0] code1;
   logic [7:0] code2;
   logic pulse1;
   logic pulse2;
   logic cool1;
   logic cool2;
   logic [3:0] therm;
   int n_fail = 0;
   int compares = 0;
   initial begin
      forever #5 i_core_clk = ~i_core_clk;
   end
   lpeg_top #(.SEC_TICKS(10)) lpeg_top_inst (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_req(req),
      .o_rdata(rdata), .o_rvalid(rvalid), .i_adc_ch1(adc1), .i_adc_ch2(adc2), .i_idle_level_select(idle_sel),
      .i_rising_trip_level(8'h1E), .i_low_current_setting(6'h0A), .i_high_current_setting(8'hC8),
      .o_load_code_ch1(code1), .o_load_code_ch2(code2), .o_pulse_ch1(pulse1), .o_pulse_ch2(pulse2),
      .o_cool_ch1(cool1), .o_cool_ch2(cool2), .o_gain_therm(therm));
   lpeg_host lpeg_host_inst (.i_core_clk(i_core_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
   task automatic complete_run();
      $display("Compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   function automatic logic sig(input int s);
      return (s == 0) ? pulse1 : (s == 1) ? cool1 : pulse2;
   endfunction
   task automatic wait_lvl(input int s, input logic v, input int lim, input bit must, output int n);
      n = 0;
      while (sig(s) !== v && n < lim) begin
         @(negedge i_core_clk);
         n++;
      end
      if (must && sig(s) !== v) begin
         n_fail++;
         $display("Error wait %0d expected %b seen timeout", s, v);
         complete_run();
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      lpeg_host_inst.wr(a, d);
   endtask
   task automatic rdv(input logic [9:0] a, output logic [15:0] d);
      bit ok;
      lpeg_host_inst.rd(a, d, ok);
      if (!ok) begin
         n_fail++;
         $display("Error rvalid %h expected 1 seen 0", a);
         complete_run();
      end
   endtask
   task automatic rdc(input logic [9:0] a, input logic [15:0] e);
      logic [15:0] d;
      rdv(a, d);
      chk("register", e, d);
   endtask
   task automatic do_reset();
      @(negedge i_core_clk);
      i_nrst = 1'b0;
      repeat (6) @(negedge i_core_clk);
      i_nrst = 1'b1;
   endtask
   task automatic t_regs();
      logic [9:0] a [8] = '{ADDR_PULSE, ADDR_METER, ADDR_LIMIT, ADDR_ACC1, ADDR_ACC2, ADDR_EN, ADDR_GAIN, 10'h000};
      logic [15:0] e [8] = '{16'h012C, 16'h0505, 16'h9BA3, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
      for (int i = 0; i < 8; i++)
         rdc(a[i], e[i]);
      wr(ADDR_PULSE, 16'h0000);
      rdc(ADDR_PULSE, 16'h0001);
      wr(ADDR_PULSE, 16'hFFFF);
      rdc(ADDR_PULSE, 16'h0FFF);
      wr(ADDR_ACC1, 16'h1234);
      rdc(ADDR_ACC1, 16'h0000);
      wr(ADDR_EN, 16'hFFFF);
      rdc(ADDR_EN, 16'hC000);
      for (int g = 0; g < 4; g++) begin
         wr(ADDR_GAIN, 16'(g));
         repeat (2) @(negedge i_core_clk);
         chk("gain", 16'(15 >> (3 - g)), {12'h000, therm});
      end
      $display("Registers test done");
   endtask
   task automatic t_pulse();
      int n;
      wr(ADDR_PULSE, 16'h0002);
      adc1 = 8'h40;
      adc2 = 8'h10;
      wait_lvl(0, 1'b1, 20, 1'b1, n);
      wait_lvl(0, 1'b0, 3000, 1'b1, n);
      chk("pulse cycles", 16'd2000, 16'(n));
      chk("code after pulse", 16'h000A, {8'h00, code1});
      chk("code below rise", 16'h000A, {8'h00, code2});
      wait_lvl(0, 1'b1, 500, 1'b0, n);
      chk("no new pulse", 16'd500, 16'(n));
      adc1 = 8'h00;
      repeat (2) @(negedge i_core_clk);
      chk("code at zero", 16'h0000, {8'h00, code1});
      wr(ADDR_PULSE, 16'h0000);
      adc1 = 8'h40;
      wait_lvl(0, 1'b1, 20, 1'b1, n);
      wait_lvl(0, 1'b0, 2000, 1'b1, n);
      chk("min pulse cycles", 16'd1000, 16'(n));
      adc2 = 8'h00;
      repeat (2) @(negedge i_core_clk);
      idle_sel = 1'b1;
      adc2 = 8'h01;
      wait_lvl(2, 1'b1, 20, 1'b1, n);
      chk("high idle code", 16'h00C8, {8'h00, code2});
      adc2 = 8'h00;
      idle_sel = 1'b0;
      $display("Pulse test done");
   endtask
   task automatic t_energy();
      int n;
      int e;
      int mul [4] = '{1, 4, 8, 16};
      logic [15:0] a0;
      logic [15:0] a1;
      logic [15:0] d;
      do_reset();
      wr(ADDR_EN, 16'h4000);
      wr(ADDR_LIMIT, 16'hFFFF);
      wr(ADDR_PULSE, 16'h0FFF);
      adc1 = 8'hFF;
      wait_lvl(0, 1'b1, 20, 1'b1, n);
      // Eight ticks per window; the read data is the accumulator over 128.
      for (int i = 0; i < 8; i++) begin
         if (i == 4)
            adc1 = 8'h00;
         wr(ADDR_METER, (i < 4) ? 16'(i << 6) : 16'(32768 + ((i - 4) << 4)));
         rdv(ADDR_ACC1, a0);
         repeat (7998) @(negedge i_core_clk);
         rdv(ADDR_ACC1, a1);
         e = (i < 4) ? (2040 * mul[i]) >> 7 : 8 >> (i - 4);
         d = (i < 4) ? a1 - a0 : a0 - a1;
         chk("energy step", 16'(e), (i < 4 && d == 16'(e + 1)) ? 16'(e) : d);
      end
      $display("Energy test done");
   endtask
   task automatic t_cool();
      int n;
      do_reset();
      wr(ADDR_EN, 16'hC000);
      wr(ADDR_LIMIT, 16'h0002);
      wr(ADDR_METER, 16'h0001);
      adc1 = 8'h80;
      adc2 = 8'h80;
      wait_lvl(1, 1'b1, 6000, 1'b1, n);
      repeat (2) @(negedge i_core_clk);
      chk("cool code", 16'h000A, {8'h00, code1});
      chk("cool ch2", 16'h0001, {15'h0000, cool2});
      rdc(ADDR_ACC1, 16'h0003);
      rdc(ADDR_ACC2, 16'h0003);
      wait_lvl(1, 1'b0, 12000, 1'b1, n);
      chk("cool length", 16'h0001, 16'(n > 9000 && n < 11000));
      // The accumulator still exceeds the limit, so cool-down is entered again.
      wr(ADDR_METER, 16'h0000);
      chk("cool again", 16'h0001, {15'h0000, cool1});
      repeat (2) @(negedge i_core_clk);
      wait_lvl(1, 1'b1, 3000, 1'b0, n);
      chk("cool disabled", 16'd3000, 16'(n));
      $display("Cool test done");
   endtask
   initial begin
      do_reset();
      t_regs();
      t_pulse();
      t_energy();
      t_cool();
      complete_run();
   end
endmodule
